// >>> cfg_host_model.sv
// Behavioural configuration host (SMBus host or EEPROM loader) on the bank's register port.
// Assumes requests launch on the falling edge and are taken on the next rising edge.
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q,
  input  wire logic       reg_rvalid_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // A released bus shows the inverse of its last value, so stale data is never mistaken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h08 && d[0] == 1'b0 && d[2] == 1'b0) return;
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid_q;
    d = reg_rdata_q;
  endtask
endmodule // cfg_host_model
`default_nettype wire

// >>> guarded_port_field.v
// One four-bit per-port field that follows its one-time-programmable value, or its inverse when INVERT_OTP is set, while locked
// and holds software or loader writes while unlocked.
// Assumes the write strobe and data come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "hub_port_config_map.vh"

module guarded_port_field #(
  parameter [3:0] RESET_VALUE = 4'h0,
  parameter       INVERT_OTP  = 1'b0
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Lock control and programmed value
  input  wire       unlocked,
  input  wire [3:0] otp_value,
  // Write port
  input  wire       wr,
  input  wire [3:0] wdata,
  // Stored field
  output reg  [3:0] field_q
);

  wire [3:0] otp_view = INVERT_OTP ? ~otp_value : otp_value;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field_q <= RESET_VALUE;
    end else if (!unlocked) begin
      field_q <= otp_view;
    end else if (wr) begin
      field_q <= wdata;
    end else begin
      field_q <= field_q;
    end
  end

endmodule // guarded_port_field
`default_nettype wire

// >>> hub_port_config_map.vh
// Register offsets, field positions and reset values for the hub port configuration bank.
// Included by every design file of the bank; holds definitions only.
`ifndef HUB_PORT_CONFIG_MAP_VH
`define HUB_PORT_CONFIG_MAP_VH

// Register offsets on the configuration register port.
`define CHARGE_PORT_ENABLES_OFS   8'h06
`define REMOVABLE_CONFIG_OFS      8'h07
`define PORT_USE_CONFIG_OFS       8'h08
`define DEVICE_CONFIG_TWO_OFS     8'h0a

// Field layout.
`define PORT_COUNT                4
`define PORT_FIELD_MSB            3
`define OVERRIDE_BIT              7
`define POL_STRAP_BIT             5

// Reset values.
`define CHARGE_RESET              4'h0
`define REMOVABLE_RESET           4'h0
`define PORT_USED_RESET           4'hf
`define LEGACY_RESET              4'h0
`define DEVICE_CONFIG_TWO_RESET   8'h10

// Strap capture: edges after reset release before the synchronised level is taken.
`define STRAP_SETTLE_EDGES        2'h2

`endif

// >>> hub_port_config_registers.v
// Port configuration register bank of a four-port hub: charging enables, removable,
// port-used and legacy-speed-only fields, with the read-only second device configuration.
// Assumes the EEPROM loader or SMBus slave drives the register port on clk, one access a cycle.
//
// Overview of operation
// - Upper reserved bits of charge and removable registers read zero, ignore writes.
// - A set charge-enable bit turns on charging features on its port.
// - Charge-enable bit n controls downstream port n+1 only.
// - Charge-enable defaults come from the power-control straps at reset release.
// - In serial configuration mode loader or SMBus may overwrite charge-enable bits.
// - Override bit locks removable, used and legacy fields to OTP, or unlocks them.
// - One write may set the override bit and load removable bits together.
// - Removable bit n reports one for a removable device on port n+1.
// - While locked, removable bits show the inverse of the OTP fixed-device field.
// - Port-used bit n enables port n+1 when one, disables when zero.
// - A legacy-speed-only port stays used and enabled whatever its port-used bit.
`timescale 1ns/10ps
`default_nettype none
`include "hub_port_config_map.vh"

module hub_port_config_registers (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Configuration source mode
  input  wire       serial_cfg_mode,
  // Register port from the EEPROM loader or SMBus slave
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  output reg        reg_rvalid_q,
  // Legacy-speed-only field, held in a register outside this bank's address set
  input  wire       legacy_wr,
  input  wire [3:0] legacy_wdata,
  // One-time-programmable values
  input  wire [3:0] otp_fixed_device,
  input  wire [3:0] otp_port_used,
  input  wire [3:0] otp_legacy_speed_only,
  // Strap pins
  input  wire [3:0] power_control_strap_pins,
  input  wire       pwr_pol_strap_pin,
  // Settings to the hub core
  output reg  [3:0] port_charge_enable_q,
  output reg  [3:0] port_removable_q,
  output reg  [3:0] port_used_q,
  output reg  [3:0] legacy_speed_only_port_q,
  output reg        removable_override_enable_q
);

  // Register port decode.
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  wire wr_charge    = reg_wr && hit(reg_addr, `CHARGE_PORT_ENABLES_OFS);
  wire wr_removable = reg_wr && hit(reg_addr, `REMOVABLE_CONFIG_OFS);
  wire wr_used      = reg_wr && hit(reg_addr, `PORT_USE_CONFIG_OFS);

  // Strap capture.
  wire [4:0] strap_value;
  wire       strap_take;

  strap_sampler u_straps (
    .clk           (clk),
    .rst_n         (rst_n),
    .strap_pins    ({pwr_pol_strap_pin, power_control_strap_pins}),
    .strap_value_q (strap_value),
    .strap_take_q  (strap_take)
  );

  // Charging enables. The strap load wins over a write in the same cycle, since the
  // loader is not expected to run before the straps have been taken.
  reg [3:0] charge_d;

  always @* begin
    charge_d = port_charge_enable_q;
    if (strap_take) begin
      charge_d = strap_value[`PORT_FIELD_MSB:0];
    end else if (wr_charge && serial_cfg_mode) begin
      charge_d = reg_wdata[`PORT_FIELD_MSB:0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_charge_enable_q <= `CHARGE_RESET;
    end else begin
      port_charge_enable_q <= charge_d;
    end
  end

  // Override bit: plain read-write control in the removable register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      removable_override_enable_q <= 1'b0;
    end else if (wr_removable) begin
      removable_override_enable_q <= reg_wdata[`OVERRIDE_BIT];
    end
  end

  // Writing override and removable bits together unlocks the field in that same write.
  wire removable_unlocked = removable_override_enable_q ||
                            (wr_removable && reg_wdata[`OVERRIDE_BIT]);

  wire [3:0] removable_field;
  wire [3:0] used_field;
  wire [3:0] legacy_field;

  guarded_port_field #(
    .RESET_VALUE (`REMOVABLE_RESET),
    .INVERT_OTP  (1'b1)
  ) u_removable (
    .clk       (clk),
    .rst_n     (rst_n),
    .unlocked  (removable_unlocked),
    .otp_value (otp_fixed_device),
    .wr        (wr_removable),
    .wdata     (reg_wdata[`PORT_FIELD_MSB:0]),
    .field_q   (removable_field)
  );

  guarded_port_field #(
    .RESET_VALUE (`PORT_USED_RESET),
    .INVERT_OTP  (1'b0)
  ) u_used (
    .clk       (clk),
    .rst_n     (rst_n),
    .unlocked  (removable_override_enable_q),
    .otp_value (otp_port_used),
    .wr        (wr_used),
    .wdata     (reg_wdata[`PORT_FIELD_MSB:0]),
    .field_q   (used_field)
  );

  guarded_port_field #(
    .RESET_VALUE (`LEGACY_RESET),
    .INVERT_OTP  (1'b0)
  ) u_legacy (
    .clk       (clk),
    .rst_n     (rst_n),
    .unlocked  (removable_override_enable_q),
    .otp_value (otp_legacy_speed_only),
    .wr        (legacy_wr),
    .wdata     (legacy_wdata),
    .field_q   (legacy_field)
  );

  // Second device configuration: only its reset state is modelled, with the polarity strap.
  reg [7:0] dev_cfg_two_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_cfg_two_q <= `DEVICE_CONFIG_TWO_RESET;
    end else if (strap_take) begin
      dev_cfg_two_q[`POL_STRAP_BIT] <= strap_value[4];
    end
  end

  // Effective settings to the hub core, one register stage behind the fields.
  // The configuring party keeps ports one and three from both being disabled; nothing
  // here repairs that combination.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_removable_q         <= `REMOVABLE_RESET;
      port_used_q              <= `PORT_USED_RESET;
      legacy_speed_only_port_q <= `LEGACY_RESET;
    end else begin
      port_removable_q         <= removable_field;
      port_used_q              <= used_field | legacy_field;
      legacy_speed_only_port_q <= legacy_field;
    end
  end

  // Read data. Reserved bits and unmapped offsets read zero.
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `CHARGE_PORT_ENABLES_OFS: begin
        rdata_d = {4'h0, port_charge_enable_q};
      end
      `REMOVABLE_CONFIG_OFS: begin
        rdata_d = {removable_override_enable_q, 3'h0, removable_field};
      end
      `PORT_USE_CONFIG_OFS: begin
        rdata_d = {4'h0, used_field};
      end
      `DEVICE_CONFIG_TWO_OFS: begin
        rdata_d = dev_cfg_two_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

endmodule // hub_port_config_registers
`default_nettype wire

// >>> hub_port_config_registers_monitor.sv
// Concurrent checks on the port configuration bank, seen from its ports only.
// Assumes one clock domain and the asynchronous active-low reset of the bank.
`timescale 1ns/10ps
`default_nettype none
module hub_cfg_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic       serial_cfg_mode,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       reg_rvalid_q,
  // Programmed values and settings
  input wire logic [3:0] otp_fixed_device,
  input wire logic [3:0] otp_port_used,
  input wire logic [3:0] otp_legacy_speed_only,
  input wire logic [3:0] port_charge_enable_q,
  input wire logic [3:0] port_removable_q,
  input wire logic [3:0] port_used_q,
  input wire logic [3:0] legacy_speed_only_port_q,
  input wire logic       removable_override_enable_q
);
  // Strap capture rewrites the charge enables just after reset, so those checks wait.
  logic [2:0] age_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) age_q <= 3'h0;
    else if (age_q != 3'h4) age_q <= age_q + 3'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid_q |-> $past(reg_rd))
    else $error("read answer without request");
  a_charge_rsvd: assert property (
    reg_rvalid_q && $past(reg_addr) == 8'h06 |-> reg_rdata_q[7:4] == 4'h0)
    else $error("charge register upper bits not zero");
  a_rmbl_rsvd: assert property (
    reg_rvalid_q && $past(reg_addr) == 8'h07 |-> reg_rdata_q[6:4] == 3'h0)
    else $error("removable register reserved bits not zero");
  a_locked_rmbl: assert property (
    (!removable_override_enable_q && $stable(otp_fixed_device)) [*3]
    |-> port_removable_q == ~otp_fixed_device)
    else $error("locked removable field not inverse of programmed value");
  a_locked_used: assert property (
    (!removable_override_enable_q && $stable(otp_port_used)) [*3]
    |-> port_used_q == (otp_port_used | otp_legacy_speed_only))
    else $error("locked used field not programmed value");
  a_legacy_used: assert property (
    (port_used_q & legacy_speed_only_port_q) == legacy_speed_only_port_q)
    else $error("legacy port not kept in use");
  a_charge_guard: assert property (
    age_q == 3'h4 && !(reg_wr && reg_addr == 8'h06 && serial_cfg_mode)
    |=> $stable(port_charge_enable_q))
    else $error("charge enables changed without an allowed write");
  a_charge_write: assert property (
    reg_wr && reg_addr == 8'h06 && serial_cfg_mode && age_q == 3'h4
    |=> {4'h0, port_charge_enable_q} == ($past(reg_wdata) & 8'h0f))
    else $error("charge enables did not take the write");
  a_unlock_load: assert property (
    reg_wr && reg_addr == 8'h07 && reg_wdata[7]
    |=> removable_override_enable_q ##1
        {4'h0, port_removable_q} == ($past(reg_wdata, 2) & 8'h0f))
    else $error("override and removable bits not loaded together");
  a_relock: assert property (
    reg_wr && reg_addr == 8'h07 && !reg_wdata[7] |=> !removable_override_enable_q)
    else $error("override bit not cleared");
endmodule // hub_cfg_monitor
bind hub_port_config_registers hub_cfg_monitor u_mon (.clk, .rst_n, .serial_cfg_mode, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .otp_fixed_device, .otp_port_used,
  .otp_legacy_speed_only, .port_charge_enable_q, .port_removable_q, .port_used_q,
  .legacy_speed_only_port_q, .removable_override_enable_q);
`default_nettype wire

// >>> hub_port_config_registers_test.sv
// Self-checking bench for the hub port configuration register bank.
// Assumes the host model drives the register port and the bench drives all other inputs.
`timescale 1ns/10ps
`default_nettype none
module hub_port_config_registers_test;
  logic       clk, rst_n, serial_cfg_mode, legacy_wr, pwr_pol_strap_pin;
  logic       reg_wr, reg_rd, reg_rvalid_q, override_q, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rd_data;
  logic [3:0] legacy_wdata, otp_fix, otp_used, otp_leg, straps, charge_q, rmbl_q, used_q, leg_q;
  int         error_cnt, checks, cycles;
  hub_port_config_registers dut (.clk, .rst_n, .serial_cfg_mode, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .legacy_wr, .legacy_wdata,
    .otp_fixed_device(otp_fix), .otp_port_used(otp_used), .otp_legacy_speed_only(otp_leg),
    .power_control_strap_pins(straps), .pwr_pol_strap_pin, .port_charge_enable_q(charge_q),
    .port_removable_q(rmbl_q), .port_used_q(used_q), .legacy_speed_only_port_q(leg_q),
    .removable_override_enable_q(override_q));
  cfg_host_model host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      end_of_test;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rd_data, ok);
    chk({7'h0, ok}, 8'h01);
    chk(rd_data, exp);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_reset;
    repeat (20) @(negedge clk);
    chk({charge_q, used_q}, 8'h0f);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk({4'h0, charge_q}, 8'h0a);
    rchk(8'h06, 8'h0a);
    rchk(8'h0a, 8'h30);
  endtask
  task automatic t_charge;
    host.wr(8'h06, 8'hf5);
    settle;
    chk({4'h0, charge_q}, 8'h0a);
    serial_cfg_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h06, 8'hf0 | (8'h01 << i));
      settle;
      chk({4'h0, charge_q}, 8'h01 << i);
    end
    rchk(8'h06, 8'h08);
  endtask
  task automatic t_locked;
    host.wr(8'h07, 8'h0a);
    host.wr(8'h08, 8'h01);
    legacy_wdata = 4'h2;
    legacy_wr = 1'b1;
    @(negedge clk);
    legacy_wr = 1'b0;
    settle;
    chk({leg_q, rmbl_q}, 8'h0c);
    chk({4'h0, used_q}, 8'h0d);
    rchk(8'h07, 8'h0c);
  endtask
  task automatic t_unlock;
    host.wr(8'h07, 8'hf5);
    settle;
    chk({3'h0, override_q, rmbl_q}, 8'h15);
    rchk(8'h07, 8'h85);
    host.wr(8'h08, 8'h0e);
    settle;
    rchk(8'h08, 8'h0e);
    legacy_wdata = 4'h1;
    legacy_wr = 1'b1;
    @(negedge clk);
    legacy_wr = 1'b0;
    settle;
    chk({leg_q, used_q}, 8'h1f);
    host.wr(8'h07, 8'h00);
    settle;
    chk({3'h0, override_q, rmbl_q}, 8'h0c);
  endtask
  initial begin
    rst_n = 1'b0;
    serial_cfg_mode = 1'b0;
    legacy_wr = 1'b0;
    legacy_wdata = 4'h0;
    pwr_pol_strap_pin = 1'b1;
    otp_fix = 4'h3;
    otp_used = 4'hd;
    otp_leg = 4'h0;
    straps = 4'ha;
    t_reset;
    t_charge;
    t_locked;
    t_unlock;
    end_of_test;
  end
endmodule // hub_port_config_registers_test
`default_nettype wire

// >>> strap_sampler.v
// Synchronises the strap pins and captures their level once after reset release.
// Assumes the straps are static pins outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "hub_port_config_map.vh"

module strap_sampler (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Raw strap pins
  input  wire [4:0] strap_pins,
  // Captured level and its one-cycle capture pulse
  output reg  [4:0] strap_value_q,
  output reg        strap_take_q
);

  reg [4:0] sync_meta_q;
  reg [4:0] sync_q;
  reg [1:0] settle_q;
  reg       done_q;

  // The first stage feeds only the second; the counter waits until the second holds a real level.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta_q   <= 5'h00;
      sync_q        <= 5'h00;
      settle_q      <= 2'h0;
      done_q        <= 1'b0;
      strap_value_q <= 5'h00;
      strap_take_q  <= 1'b0;
    end else begin
      sync_meta_q  <= strap_pins;
      sync_q       <= sync_meta_q;
      strap_take_q <= 1'b0;
      if (!done_q) begin
        if (settle_q == `STRAP_SETTLE_EDGES) begin
          strap_value_q <= sync_q;
          strap_take_q  <= 1'b1;
          done_q        <= 1'b1;
        end else begin
          settle_q <= settle_q + 2'h1;
        end
      end
    end
  end

endmodule // strap_sampler
`default_nettype wire
